// [hw/shp_pkg.sv]
// Shared constants and state types for the serial pause link
package shp_pkg;

    // =========================================================================
    // Clocking and link timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Host serial clock half period; long enough for both synchronisers
    localparam int unsigned SCK_HALF_NS = 80;
    localparam int unsigned SCK_HALF_CYC =
        (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;

    // =========================================================================
    // Serial framing
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] IDX_ZERO = 8'h00;
    localparam logic [7:0] IDX_ONE = 8'h01;
    localparam logic [7:0] IDX_MAX = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // =========================================================================
    // Instructions and status register
    localparam logic [7:0] INSTR_RDSR = 8'h05;
    localparam logic [7:0] INSTR_WRSR = 8'h01;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Mode bits 7:6 and pause disable bit 0 are writable, the rest read zero
    localparam logic [7:0] STATUS_WMASK = 8'hc1;
    localparam int unsigned STATUS_PAUSE_DIS_BIT = 0;

    // =========================================================================
    // State machines
    typedef enum logic [4:0] {
        SHP_DEV_IDLE    = 5'b00001,
        SHP_DEV_ACTIVE  = 5'b00010,
        SHP_DEV_PENDING = 5'b00100,
        SHP_DEV_PAUSED  = 5'b01000,
        SHP_DEV_STUCK   = 5'b10000
    } shp_dev_state_t;

    typedef enum logic [3:0] {
        SHP_HOST_IDLE  = 4'b0001,
        SHP_HOST_LOAD  = 4'b0010,
        SHP_HOST_SHIFT = 4'b0100,
        SHP_HOST_PAUSE = 4'b1000
    } shp_host_state_t;

endpackage : shp_pkg

// [hw/shp_if.sv]
// Serial link pins between the memory device end and the bus master end
`timescale 1ns/10ps
interface shp_if;
    logic cs_n;
    logic sck;
    logic si;
    logic pause_n;
    logic so;
    logic so_oe;
    wire so_w;

    // A released output reads as the inverse of its last bit, so a sample
    // taken while the device floats it shows up as wrong data
    assign so_w = so_oe ? so : ~so;

    modport dev (
        input cs_n,
        input sck,
        input si,
        input pause_n,
        output so,
        output so_oe
    );

    modport host (
        output cs_n,
        output sck,
        output si,
        output pause_n,
        input so_w
    );
endinterface : shp_if

// [hw/shp_dev.sv]
// Serial memory device end: bit shifter, status byte and pause control
`timescale 1ns/10ps

//
// Contract
// - Master holds pause high when not pausing
// - Low pause while selected suspends serial traffic
// - Partial instruction, address or data survives pause
// - Master lowers pause only while clock low
// - Pause during clock high waits for falling
// - Master keeps chip select low throughout pause
// - Paused device floats serial output, ignores pins
// - Paused: no shifting, no sequence advance
// - Master releases pause while clock low
// - Release during clock high keeps device paused
// - Pause low floats serial output immediately unless status bit 0 disables pause
// - Status bit disables pause feature
// - Status bit 0 zero enables, one disables
// - Capture on rising, drive output after falling
// - Deselected device floats serial output
module shp_dev (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    shp_if.dev link,
    input wire logic [7:0] tx_byte_i,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic [7:0] rx_index_o,
    output logic [7:0] status_o,
    output logic paused_o,
    output logic selected_o
);
    import shp_pkg::*;

    // =========================================================================
    // Pin synchronisers
    localparam int unsigned NPIN = 4;
    localparam int unsigned PIN_CS = 3;
    localparam int unsigned PIN_SCK = 2;
    localparam int unsigned PIN_SI = 1;
    localparam int unsigned PIN_PAUSE = 0;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;
    logic sck_prev_q;

    assign pin_raw = {link.cs_n, link.sck, link.si, link.pause_n};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    // Every pin but the clock resets high; the clock idles low, so no false edge
                    sync1_q[gi] <= (gi != PIN_SCK);
                    sync2_q[gi] <= (gi != PIN_SCK);
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic pause_n_s;
    logic sck_rise;
    logic sck_fall;

    assign cs_n_s = sync2_q[PIN_CS];
    assign sck_s = sync2_q[PIN_SCK];
    assign si_s = sync2_q[PIN_SI];
    assign pause_n_s = sync2_q[PIN_PAUSE];
    assign sck_rise = sck_s & ~sck_prev_q;
    assign sck_fall = ~sck_s & sck_prev_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
        end
    end

    // =========================================================================
    // Pause control
    logic [7:0] status_q;
    logic pause_en;
    shp_dev_state_t state_q;
    shp_dev_state_t state_d;

    assign pause_en = ~status_q[STATUS_PAUSE_DIS_BIT];

    always_comb begin
        state_d = state_q;
        case (state_q)
            SHP_DEV_IDLE: begin
                if (!cs_n_s) begin
                    state_d = SHP_DEV_ACTIVE;
                end
            end
            SHP_DEV_ACTIVE: begin
                if (pause_en && !pause_n_s) begin
                    // Clock low pauses at once, clock high waits for its fall
                    state_d = sck_s ? SHP_DEV_PENDING : SHP_DEV_PAUSED;
                end
            end
            SHP_DEV_PENDING: begin
                if (sck_fall) begin
                    state_d = SHP_DEV_PAUSED;
                end
            end
            SHP_DEV_PAUSED: begin
                if (pause_n_s) begin
                    // A release with the clock high is not honoured
                    state_d = sck_s ? SHP_DEV_STUCK : SHP_DEV_ACTIVE;
                end
            end
            SHP_DEV_STUCK: begin
                if (!pause_n_s) begin
                    state_d = SHP_DEV_PAUSED;
                end
            end
            default: begin
                state_d = SHP_DEV_IDLE;
            end
        endcase
        if (cs_n_s) begin
            state_d = SHP_DEV_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= SHP_DEV_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Shifting in the active and pending states only; a rising edge that meets the pause is taken
    // while still active, as pending is entered with the clock already high and left on its fall
    logic shift_ok;
    assign shift_ok = (state_q == SHP_DEV_ACTIVE) || (state_q == SHP_DEV_PENDING);

    // =========================================================================
    // Receive shifter and byte sequencing
    logic [7:0] rx_sh_q;
    logic [2:0] bit_q;
    logic [7:0] idx_q;
    logic [7:0] cmd_q;
    logic [7:0] rx_full;

    assign rx_full = {rx_sh_q[6:0], si_s};

    // Frozen while paused, cleared by reset or deselection
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || cs_n_s) begin
            rx_sh_q <= BYTE_ZERO;
            bit_q <= BIT_FIRST;
            idx_q <= IDX_ZERO;
            cmd_q <= BYTE_ZERO;
        end else if (shift_ok && sck_rise) begin
            rx_sh_q <= rx_full;
            bit_q <= bit_q + 3'h1;
            if (bit_q == BIT_LAST) begin
                if (idx_q != IDX_MAX) begin
                    idx_q <= idx_q + IDX_ONE;
                end
                if (idx_q == IDX_ZERO) begin
                    cmd_q <= rx_full;
                end
            end
        end
    end

    logic byte_done;
    assign byte_done = shift_ok && sck_rise && (bit_q == BIT_LAST);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_byte_o <= BYTE_ZERO;
            rx_valid_o <= 1'b0;
            rx_index_o <= IDX_ZERO;
        end else begin
            rx_valid_o <= byte_done;
            if (byte_done) begin
                rx_byte_o <= rx_full;
                rx_index_o <= idx_q;
            end
        end
    end

    // Status byte written by the second byte of a status write
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            status_q <= STATUS_RESET;
        end else if (byte_done && idx_q == IDX_ONE && cmd_q == INSTR_WRSR) begin
            status_q <= rx_full & STATUS_WMASK;
        end
    end

    // =========================================================================
    // Transmit shifter, updated after falling edges
    logic [7:0] tx_sh_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || cs_n_s) begin
            tx_sh_q <= BYTE_ZERO;
        end else if (state_q == SHP_DEV_ACTIVE && sck_fall) begin
            if (bit_q == BIT_FIRST && idx_q != IDX_ZERO) begin
                tx_sh_q <= (cmd_q == INSTR_RDSR) ? status_q : tx_byte_i;
            end else begin
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
        end
    end

    // =========================================================================
    // Pin and user outputs
    logic drive_ok;
    // A low pause level floats the output while pause is enabled, even before the pause takes hold
    assign drive_ok = ~cs_n_s & (state_q == SHP_DEV_ACTIVE) & (pause_n_s | ~pause_en);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            link.so <= 1'b0;
            link.so_oe <= 1'b0;
            status_o <= STATUS_RESET;
            paused_o <= 1'b0;
            selected_o <= 1'b0;
        end else begin
            link.so <= tx_sh_q[7];
            link.so_oe <= drive_ok;
            status_o <= status_q;
            paused_o <= (state_q == SHP_DEV_PAUSED) || (state_q == SHP_DEV_STUCK);
            selected_o <= ~cs_n_s;
        end
    end

endmodule : shp_dev

// [hw/shp_host.sv]
// Bus master end: makes the serial clock, sends bytes and pauses on request
`timescale 1ns/10ps
module shp_host (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    shp_if.host link,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    input wire logic end_i,
    input wire logic pause_req_i,
    output logic tx_take_o,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic busy_o,
    output logic paused_o
);
    import shp_pkg::*;

    // =========================================================================
    // Serial output synchroniser
    logic so_s1_q;
    logic so_s2_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            so_s1_q <= 1'b0;
            so_s2_q <= 1'b0;
        end else begin
            so_s1_q <= link.so_w;
            so_s2_q <= so_s1_q;
        end
    end

    // =========================================================================
    // Sequencer
    shp_host_state_t state_q;
    logic [DIV_W-1:0] div_q;
    logic [2:0] bit_q;
    logic [7:0] tx_sh_q;
    logic [7:0] rx_sh_q;
    logic half_done;

    assign half_done = (div_q == DIV_LAST);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= SHP_HOST_IDLE;
            div_q <= DIV_ZERO;
            bit_q <= BIT_FIRST;
            tx_sh_q <= BYTE_ZERO;
            rx_sh_q <= BYTE_ZERO;
            link.cs_n <= 1'b1;
            link.sck <= 1'b0;
            link.si <= 1'b0;
            link.pause_n <= 1'b1;
            tx_take_o <= 1'b0;
            rx_byte_o <= BYTE_ZERO;
            rx_valid_o <= 1'b0;
        end else begin
            tx_take_o <= 1'b0;
            rx_valid_o <= 1'b0;
            div_q <= half_done ? DIV_ZERO : div_q + 8'h01;
            case (state_q)
                SHP_HOST_IDLE, SHP_HOST_LOAD: begin
                    if (tx_valid_i) begin
                        link.cs_n <= 1'b0;
                        link.si <= tx_byte_i[7];
                        tx_sh_q <= tx_byte_i;
                        tx_take_o <= 1'b1;
                        bit_q <= BIT_FIRST;
                        div_q <= DIV_ZERO;
                        state_q <= SHP_HOST_SHIFT;
                    end else if (end_i && state_q == SHP_HOST_LOAD) begin
                        link.cs_n <= 1'b1;
                        state_q <= SHP_HOST_IDLE;
                    end
                end
                SHP_HOST_SHIFT: begin
                    if (!link.sck && div_q == DIV_ZERO && pause_req_i) begin
                        // Pause only at the start of a low phase
                        link.pause_n <= 1'b0;
                        state_q <= SHP_HOST_PAUSE;
                    end else if (half_done) begin
                        link.sck <= ~link.sck;
                        if (!link.sck) begin
                            rx_sh_q <= {rx_sh_q[6:0], so_s2_q};
                        end else begin
                            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                            link.si <= tx_sh_q[6];
                            bit_q <= bit_q + 3'h1;
                            if (bit_q == BIT_LAST) begin
                                rx_byte_o <= rx_sh_q;
                                rx_valid_o <= 1'b1;
                                state_q <= SHP_HOST_LOAD;
                            end
                        end
                    end
                end
                SHP_HOST_PAUSE: begin
                    div_q <= DIV_ZERO;
                    if (!pause_req_i) begin
                        // Clock is low here; seven more low cycles follow, completing the eight-cycle low half period
                        link.pause_n <= 1'b1;
                        div_q <= 8'h01;
                        state_q <= SHP_HOST_SHIFT;
                    end
                end
                default: begin
                    state_q <= SHP_HOST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            paused_o <= 1'b0;
        end else begin
            busy_o <= (state_q != SHP_HOST_IDLE);
            paused_o <= (state_q == SHP_HOST_PAUSE);
        end
    end

endmodule : shp_host

// [bench/shp_properties.sv]
// Concurrent checks on the serial pause link between host and device ends
`timescale 1ns/10ps
module shp_properties (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic pause_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic [7:0] status_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    logic sck_q;
    logic [3:0] fall_age_q;

    // =========================================================================
    // Cycles since the serial clock last fell, saturating
    always_ff @(posedge ref_clk_i) begin
        sck_q <= rst_i ? 1'b0 : sck;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || (sck_q && !sck)) begin
            fall_age_q <= 4'h0;
        end else if (fall_age_q != 4'hf) begin
            fall_age_q <= fall_age_q + 4'h1;
        end
    end

    // =========================================================================
    // Pause sequences
    sequence pause_entry_s;
        $fell(pause_n) && !status_o[0];
    endsequence

    sequence pause_held_s;
        (!pause_n && !cs_n && !status_o[0]) [*5];
    endsequence

    // =========================================================================
    // Properties
    idle_pause_high_a: assert property (cs_n |-> pause_n)
        else $error("pause low while deselected");
    entry_clock_low_a: assert property ($fell(pause_n) |-> !sck && !$past(sck))
        else $error("pause entered with serial clock high");
    resume_clock_low_a: assert property ($rose(pause_n) |-> !sck && !$past(sck))
        else $error("pause released with serial clock high");
    pause_keeps_select_a: assert property (!pause_n |=> !cs_n)
        else $error("chip select raised during pause");
    clock_frozen_a: assert property (!pause_n |=> $stable(sck))
        else $error("serial clock moved during pause");
    pause_floats_so_a: assert property (pause_entry_s |-> ##[0:4] !so_oe)
        else $error("output not floated after pause");
    paused_float_a: assert property (pause_held_s |-> !so_oe)
        else $error("output driven while paused");
    deselect_float_a: assert property (cs_n [*5] |-> !so_oe)
        else $error("output driven while deselected");
    so_after_fall_a: assert property (so_oe && $past(so_oe) && $changed(so) |-> fall_age_q <= 4'h8)
        else $error("output changed away from a clock fall");
    disabled_drive_a: assert property ($fell(pause_n) && status_o[0] && so_oe |=> so_oe)
        else $error("disabled pause floated the output");
endmodule : shp_properties

// [bench/shp_bench.sv]
// Self-checking bench: host and device ends, plus a device end driven by the bench
`timescale 1ns/10ps
module shp_bench;
    import shp_pkg::*;

    typedef struct packed {
        logic [7:0] instr;
        logic [7:0] data;
        logic pause;
        logic exp_pause;
        logic [7:0] exp_rx;
        logic [7:0] exp_status;
    } shp_row_t;

    localparam int N_ROWS = 7;
    // Status writes go through the 0xc1 mask; a pause is honoured only while bit 0 is clear
    localparam shp_row_t ROWS [N_ROWS] = '{
        '{INSTR_WRSR, 8'hff, 1'b0, 1'b0, 8'h00, 8'hc1},
        '{INSTR_RDSR, 8'h00, 1'b1, 1'b0, 8'hc1, 8'hc1},
        '{INSTR_WRSR, 8'h3e, 1'b1, 1'b0, 8'h00, 8'h00},
        '{INSTR_RDSR, 8'h00, 1'b1, 1'b1, 8'h00, 8'h00},
        '{8'h03, 8'h00, 1'b1, 1'b1, 8'h5a, 8'h00},
        '{INSTR_WRSR, 8'h40, 1'b0, 1'b0, 8'h00, 8'h40},
        '{INSTR_RDSR, 8'h00, 1'b0, 1'b0, 8'h40, 8'h40}
    };

    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] tx_byte = 8'h00;
    logic tx_valid = 1'b0;
    logic end_frame = 1'b0;
    logic pause_req = 1'b0;
    logic [7:0] dev_tx = 8'h5a;
    logic tx_take, h_rx_valid, h_busy, h_paused, d_rx_valid, d_paused, d_sel, b_valid, b_paused;
    logic b_sel;
    logic [7:0] h_rx, d_rx, d_idx, d_status, b_rx, b_idx, d_got, b_got, b_ix;
    logic seen_pause = 1'b0;
    int n_fail = 0;
    int samples_checked = 0;

    shp_if link_a ();
    shp_if link_b ();

    shp_host u_shp_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link_a),
        .tx_byte_i(tx_byte), .tx_valid_i(tx_valid), .end_i(end_frame),
        .pause_req_i(pause_req), .tx_take_o(tx_take), .rx_byte_o(h_rx),
        .rx_valid_o(h_rx_valid), .busy_o(h_busy), .paused_o(h_paused));
    shp_dev u_shp_dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link_a),
        .tx_byte_i(dev_tx), .rx_byte_o(d_rx), .rx_valid_o(d_rx_valid), .rx_index_o(d_idx),
        .status_o(d_status), .paused_o(d_paused), .selected_o(d_sel));
    shp_dev u_shp_dev_b (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link_b),
        .tx_byte_i(8'h00), .rx_byte_o(b_rx), .rx_valid_o(b_valid), .rx_index_o(b_idx),
        .status_o(), .paused_o(b_paused), .selected_o(b_sel));
    shp_properties u_shp_properties (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .cs_n(link_a.cs_n), .sck(link_a.sck), .pause_n(link_a.pause_n), .so(link_a.so),
        .so_oe(link_a.so_oe), .status_o(d_status));

    always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i) begin
        if (d_paused === 1'b1) seen_pause <= 1'b1;
        if (d_rx_valid === 1'b1 && d_idx === 8'h01) d_got <= d_rx;
        if (b_valid === 1'b1) b_got <= b_rx;
        if (b_valid === 1'b1) b_ix <= b_idx;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic send_byte(input logic [7:0] b, input logic p);
        tx_byte <= b;
        tx_valid <= 1'b1;
        for (int i = 0; i < 20 && tx_take !== 1'b1; i++) @(posedge ref_clk_i);
        tx_valid <= 1'b0;
        if (p) begin
            repeat (40) @(posedge ref_clk_i);
            pause_req <= 1'b1;
            repeat (30) @(posedge ref_clk_i);
            chk("host_paused", 8'h01, {7'h0, h_paused});
            pause_req <= 1'b0;
        end
        for (int i = 0; i < 400 && h_rx_valid !== 1'b1; i++) @(posedge ref_clk_i);
        chk("byte_done", 8'h01, {7'h0, h_rx_valid});
        chk("dev_sel", 8'h01, {7'h0, d_sel});
    endtask : send_byte

    task automatic run_frame(input shp_row_t r);
        seen_pause = 1'b0;
        send_byte(r.instr, 1'b0);
        send_byte(r.data, r.pause);
        end_frame <= 1'b1;
        for (int i = 0; i < 20 && h_busy !== 1'b0; i++) @(posedge ref_clk_i);
        end_frame <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        chk("dev_desel", 8'h00, {7'h0, d_sel});
    endtask : run_frame

    // Bench-made link clock with a 125 ns period; it is left low between calls
    task automatic bb_bits(input logic [7:0] v, input int hi, input int lo);
        for (int i = hi; i >= lo; i--) begin
            link_b.si <= v[i];
            #62.5 link_b.sck <= 1'b1;
            #62.5 link_b.sck <= 1'b0;
        end
    endtask : bb_bits

    initial begin
        #100us;
        n_fail++;
        conclude();
    end

    initial begin
        link_b.cs_n = 1'b1;
        link_b.sck = 1'b0;
        link_b.si = 1'b0;
        link_b.pause_n = 1'b1;
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        chk("idle_pins", 8'h02, {6'h0, link_a.pause_n, link_a.so_oe});
        chk("status_rst", 8'h00, d_status);
        for (int i = 0; i < N_ROWS; i++) begin
            run_frame(ROWS[i]);
            chk("status", ROWS[i].exp_status, d_status);
            chk("dev_byte", ROWS[i].data, d_got);
            chk("paused", {7'h0, ROWS[i].exp_pause}, {7'h0, seen_pause});
            if (ROWS[i].instr != INSTR_WRSR) begin
                chk("host_rx", ROWS[i].exp_rx, h_rx);
            end
        end
        // Offset keeps pin changes and checks clear of the sampling edge
        #2 link_b.cs_n <= 1'b0;
        #100 bb_bits(8'ha5, 7, 5);
        link_b.si <= 1'b0;
        #62.5 link_b.sck <= 1'b1;
        #30 link_b.pause_n <= 1'b0;
        #20 chk("pending", 8'h00, {7'h0, b_paused});
        #12.5 link_b.sck <= 1'b0;
        chk("pending_so", 8'h00, {7'h0, link_b.so_oe});
        #100 chk("held", 8'h01, {7'h0, b_paused});
        chk("held_so", 8'h00, {7'h0, link_b.so_oe});
        bb_bits(8'hff, 7, 5);
        link_b.pause_n <= 1'b1;
        #100 bb_bits(8'ha5, 3, 0);
        #100 chk("byte_a", 8'ha5, b_got);
        bb_bits(8'h3c, 7, 4);
        link_b.pause_n <= 1'b0;
        #62.5 link_b.sck <= 1'b1;
        #30 link_b.pause_n <= 1'b1;
        #32.5 link_b.sck <= 1'b0;
        #100 chk("stuck", 8'h01, {7'h0, b_paused});
        link_b.pause_n <= 1'b0;
        #62.5 link_b.pause_n <= 1'b1;
        #100 chk("resumed", 8'h00, {7'h0, b_paused});
        bb_bits(8'h3c, 3, 0);
        #100 chk("byte_b", 8'h3c, b_got);
        chk("index_b", 8'h01, b_ix);
        bb_bits(8'hff, 7, 5);
        link_b.pause_n <= 1'b0;
        #100 link_b.cs_n <= 1'b1;
        link_b.pause_n <= 1'b1;
        #100 chk("abandon", 8'h00, {5'h0, link_b.so_oe, b_paused, b_sel});
        link_b.cs_n <= 1'b0;
        #100 bb_bits(8'h81, 7, 0);
        #100 chk("byte_c", 8'h81, b_got);
        chk("index_c", 8'h00, b_ix);
        conclude();
    end
endmodule : shp_bench
